// file: hw/sfp_flash_seq.sv
// Serial flash command sequencer: status write, reads and page program.
`timescale 1ns/10ps
module sfp_flash_seq #(
    parameter int MEM_AW              = 16,
    parameter int STATUS_WRITE_TIME_NS = 4000,
    parameter int PAGE_WRITE_TIME_NS   = 40000
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 spi_clk,
    input  wire logic                 chip_select_b,
    input  wire logic                 serial_in,
    input  wire logic                 write_protect_b,
    output logic                      serial_out,
    output logic                      serial_out_oe,
    output sfp_pkg::sfp_status_t      status,
    output logic                      hardware_locked_mode
);
    import sfp_pkg::*;

    localparam int SW_CYC   = (STATUS_WRITE_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int PP_CYC   = (PAGE_WRITE_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int PP_WAIT  = (PP_CYC > 2 * PAGE_BYTES) ? PP_CYC - PAGE_BYTES - 1 : 1;
    localparam logic [31:0] SW_LAST = 32'(SW_CYC - 1);
    localparam logic [31:0] PP_LAST = 32'(PP_WAIT - 1);

    // ---------------- Link domain (spi_clk) ----------------
    logic              link_arst_b;
    logic [2:0]        bit_ff;
    logic [2:0]        idx_ff;
    logic [6:0]        shift_ff;
    logic [7:0]        hold_ff;
    logic              tgl_ff;
    logic [7:0]        op_ff;
    logic [23:0]       addr_ff;
    logic              rd_ok_ff;
    logic              out_act_ff;
    logic              busy_s1_ff;
    logic              busy_s2_ff;
    logic [7:0]        sh_out_ff;
    logic              oe_ff;
    logic [7:0]        full_byte;
    logic              byte_done;
    logic              issue;
    logic [23:0]       issue_addr;
    logic [MEM_AW-1:0] mem_raddr;
    logic [MEM_AW-1:0] nxt_rd_addr;
    logic [7:0]        mem_q;

    // Select high clears all link state; the link clock may stop outside frames.
    assign link_arst_b = rst_b & ~chip_select_b;
    assign full_byte   = {shift_ff, serial_in};
    assign byte_done   = (bit_ff == BIT_LAST);
    assign issue       = rd_ok_ff && byte_done &&
                         ((op_ff == OP_READ && idx_ff >= IDX_ADDR_LAST) ||
                          (op_ff == OP_FAST_READ && idx_ff >= IDX_DUMMY));
    assign issue_addr  = (idx_ff == IDX_ADDR_LAST) ? {addr_ff[15:0], full_byte} : addr_ff;
    assign mem_raddr   = issue_addr[MEM_AW-1:0];
    // Incrementing inside the array width rolls the top address over to zero.
    assign nxt_rd_addr = mem_raddr + 1'b1;

    // Busy level into the link domain; it settles during the opcode bits.
    always_ff @(posedge spi_clk or negedge link_arst_b) begin
        if (!link_arst_b) begin
            busy_s1_ff <= 1'b0;
            busy_s2_ff <= 1'b0;
        end else begin
            busy_s1_ff <= status.cycle_in_progress;
            busy_s2_ff <= busy_s1_ff;
        end
    end

    // Input shifting on rising edges, byte hand-off to the core by bit toggle.
    always_ff @(posedge spi_clk or negedge link_arst_b) begin
        if (!link_arst_b) begin
            bit_ff   <= '0;
            idx_ff   <= '0;
            shift_ff <= '0;
            hold_ff  <= '0;
            tgl_ff   <= 1'b0;
        end else begin
            bit_ff   <= bit_ff + 1'b1;
            shift_ff <= full_byte[6:0];
            tgl_ff   <= ~tgl_ff;
            if (byte_done) begin
                hold_ff <= full_byte;
                if (idx_ff != IDX_SAT) begin
                    idx_ff <= idx_ff + 1'b1;
                end
            end
        end
    end

    // Read decode and address counter.
    always_ff @(posedge spi_clk or negedge link_arst_b) begin
        if (!link_arst_b) begin
            op_ff      <= '0;
            addr_ff    <= '0;
            rd_ok_ff   <= 1'b0;
            out_act_ff <= 1'b0;
        end else if (byte_done) begin
            if (idx_ff == IDX_OPCODE) begin
                op_ff    <= full_byte;
                rd_ok_ff <= !busy_s2_ff;
            end
            if (issue) begin
                addr_ff    <= 24'(nxt_rd_addr);
                out_act_ff <= 1'b1;
            end else if (idx_ff >= IDX_ADDR_FIRST && idx_ff <= IDX_ADDR_LAST) begin
                addr_ff <= {addr_ff[15:0], full_byte};
            end
        end
    end

    // Output shifter on falling edges; released as soon as select rises.
    always_ff @(negedge spi_clk or negedge link_arst_b) begin
        if (!link_arst_b) begin
            sh_out_ff <= '0;
            oe_ff     <= 1'b0;
        end else begin
            oe_ff <= out_act_ff;
            if (out_act_ff && bit_ff == '0) begin
                sh_out_ff <= mem_q;
            end else begin
                sh_out_ff <= {sh_out_ff[6:0], 1'b0};
            end
        end
    end

    assign serial_out    = sh_out_ff[7];
    assign serial_out_oe = oe_ff;

    // ---------------- Core domain (ref_clk) ----------------
    logic                rst_s1_ff;
    logic                rst_n_ff;
    logic                cs_s1_ff;
    logic                cs_s2_ff;
    logic                cs_s3_ff;
    logic                tg_s1_ff;
    logic                tg_s2_ff;
    logic                tg_s3_ff;
    logic                wp_s1_ff;
    logic                wp_s2_ff;
    logic                bit_evt;
    logic                frame_start;
    logic                frame_end;
    logic                byte_evt;
    logic [2:0]          cbit_ff;
    logic [2:0]          cbyte_ff;
    logic [7:0]          cop_ff;
    logic [23:0]         paddr_ff;
    logic [PAGE_AW-1:0]  poff_ff;
    sfp_status_t         sdata_ff;
    logic                fr_idle_ff;
    logic [PAGE_BYTES-1:0] mask_ff;
    logic                pb_we;
    logic [7:0]          pb_q;
    logic                locked;
    logic                prot;
    logic [2:0]          region;
    logic                aligned;
    logic                unlock_go;
    logic                sw_go;
    logic                prog_go;
    sfp_state_t          state_ff;
    logic [31:0]         cyc_ff;
    logic [PAGE_AW:0]    cp_idx_ff;
    logic [PAGE_AW-1:0]  cp_off_ff;
    logic                cp_pend_ff;
    sfp_status_t         status_ff;
    logic                lock_ff;
    logic                arr_we;

    // Reset release through two flops.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // Pin and cross-domain synchronisers; the second stage is read, and select and toggle also use a third stage for edges.
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
            tg_s1_ff <= 1'b0;
            tg_s2_ff <= 1'b0;
            tg_s3_ff <= 1'b0;
            wp_s1_ff <= 1'b1;
            wp_s2_ff <= 1'b1;
        end else begin
            cs_s1_ff <= chip_select_b;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            tg_s1_ff <= tgl_ff;
            tg_s2_ff <= tg_s1_ff;
            tg_s3_ff <= tg_s2_ff;
            wp_s1_ff <= write_protect_b;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    // A bit toggle always lands well before the select rise that follows it.
    assign bit_evt     = tg_s2_ff ^ tg_s3_ff;
    assign frame_start = cs_s3_ff & ~cs_s2_ff;
    assign frame_end   = cs_s2_ff & ~cs_s3_ff;
    assign byte_evt    = bit_evt && cbit_ff == BIT_LAST;
    assign aligned     = (cbit_ff == '0);
    assign locked      = status_ff.status_guard_bit & ~wp_s2_ff;
    // Guarded area grows from the top of the array in eighths.
    assign region      = paddr_ff[MEM_AW-1 -: 3];
    assign prot        = (status_ff.block_guard == GUARD_ALL) ||
                         (status_ff.block_guard != '0 &&
                          ({1'b0, region} + {1'b0, status_ff.block_guard}) >= GUARD_REGIONS);
    assign pb_we       = byte_evt && cbyte_ff >= IDX_FIRST_DATA &&
                         cop_ff == OP_PAGE_PROGRAM && fr_idle_ff;
    // Anything other than exact byte counts (at least five for page program) on a boundary is dropped untouched.
    assign unlock_go   = frame_end && aligned && cbyte_ff == LEN_UNLOCK &&
                         cop_ff == OP_WRITE_UNLOCK && state_ff == ST_IDLE;
    assign sw_go       = frame_end && aligned && cbyte_ff == LEN_STATUS_WRITE &&
                         cop_ff == OP_STATUS_WRITE && status_ff.write_unlock_latch &&
                         !locked && state_ff == ST_IDLE;
    assign prog_go     = frame_end && aligned && cbyte_ff >= LEN_PROG_MIN &&
                         cop_ff == OP_PAGE_PROGRAM && status_ff.write_unlock_latch &&
                         fr_idle_ff && state_ff == ST_IDLE && !prot;

    // Frame tracking in the core: bit and byte counts, opcode and address.
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cbit_ff    <= '0;
            cbyte_ff   <= '0;
            cop_ff     <= '0;
            paddr_ff   <= '0;
            poff_ff    <= '0;
            sdata_ff   <= STATUS_RST;
            fr_idle_ff <= 1'b0;
        end else if (frame_start) begin
            cbit_ff    <= '0;
            cbyte_ff   <= '0;
            fr_idle_ff <= (state_ff == ST_IDLE);
        end else if (bit_evt) begin
            cbit_ff <= cbit_ff + 1'b1;
            if (byte_evt) begin
                if (cbyte_ff != IDX_SAT) begin
                    cbyte_ff <= cbyte_ff + 1'b1;
                end
                if (cbyte_ff == IDX_OPCODE) begin
                    cop_ff <= hold_ff;
                end else if (fr_idle_ff && cbyte_ff <= IDX_ADDR_LAST) begin
                    // A frame begun during a timed cycle must not move that cycle's page.
                    paddr_ff <= {paddr_ff[15:0], hold_ff};
                    poff_ff  <= hold_ff;
                end else if (fr_idle_ff) begin
                    poff_ff <= poff_ff + 1'b1;
                end
                // The pending status byte is frozen while its own cycle runs.
                if (cbyte_ff == IDX_ADDR_FIRST && state_ff != ST_SW_WAIT) begin
                    sdata_ff <= sfp_status_t'(hold_ff);
                end
            end
        end
    end

    // Bytes written by this frame; untouched offsets keep their contents.
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mask_ff <= '0;
        end else if (state_ff == ST_PROG_COPY && cp_idx_ff[PAGE_AW]) begin
            mask_ff <= '0;
        end else if (frame_start && state_ff == ST_IDLE) begin
            mask_ff <= '0;
        end else if (pb_we) begin
            mask_ff[poff_ff] <= 1'b1;
        end
    end

    sfp_page_buf #(
        .AW    (PAGE_AW)
    ) u_page_buf (
        .clk   (ref_clk),
        .we    (pb_we),
        .waddr (poff_ff),
        .wdata (hold_ff),
        .raddr (cp_idx_ff[PAGE_AW-1:0]),
        .rdata (pb_q)
    );

    // Self-timed cycle sequencer.
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff   <= ST_IDLE;
            cyc_ff     <= '0;
            cp_idx_ff  <= '0;
            cp_off_ff  <= '0;
            cp_pend_ff <= 1'b0;
        end else begin
            cp_pend_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    cyc_ff    <= '0;
                    cp_idx_ff <= '0;
                    if (sw_go) begin
                        state_ff <= ST_SW_WAIT;
                    end else if (prog_go) begin
                        state_ff <= ST_PROG_WAIT;
                    end
                end
                ST_SW_WAIT: begin
                    cyc_ff <= cyc_ff + 1'b1;
                    if (cyc_ff == SW_LAST) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_PROG_WAIT: begin
                    cyc_ff <= cyc_ff + 1'b1;
                    if (cyc_ff == PP_LAST) begin
                        state_ff <= ST_PROG_COPY;
                    end
                end
                ST_PROG_COPY: begin
                    // The buffer read is registered, so writes trail the index by one.
                    cp_pend_ff <= !cp_idx_ff[PAGE_AW];
                    cp_off_ff  <= cp_idx_ff[PAGE_AW-1:0];
                    cp_idx_ff  <= cp_idx_ff + 1'b1;
                    if (cp_idx_ff[PAGE_AW]) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Only offsets written in the frame reach the array, all within the page.
    assign arr_we = cp_pend_ff && mask_ff[cp_off_ff];

    sfp_array_mem #(
        .AW      (MEM_AW)
    ) u_array (
        .wr_clk  (ref_clk),
        .wr_en   (arr_we),
        .wr_addr ({paddr_ff[MEM_AW-1:PAGE_AW], cp_off_ff}),
        .wr_data (pb_q),
        .rd_clk  (spi_clk),
        .rd_en   (issue),
        .rd_addr (mem_raddr),
        .rd_data (mem_q)
    );

    // Status register: busy flag, unlock latch and the guard fields.
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            status_ff <= STATUS_RST;
            lock_ff   <= 1'b0;
        end else begin
            lock_ff <= locked;
            status_ff.rsv <= '0;
            status_ff.cycle_in_progress <= (state_ff != ST_IDLE) || sw_go || prog_go;
            if (unlock_go) begin
                status_ff.write_unlock_latch <= 1'b1;
            end else if (state_ff == ST_PROG_COPY) begin
                status_ff.write_unlock_latch <= 1'b0;
            end else if (state_ff == ST_SW_WAIT && cyc_ff == SW_LAST) begin
                status_ff.write_unlock_latch <= 1'b0;
                status_ff.block_guard        <= sdata_ff.block_guard;
                status_ff.status_guard_bit   <= sdata_ff.status_guard_bit;
            end
        end
    end

    assign status               = status_ff;
    assign hardware_locked_mode = lock_ff;

    // ---------------- Checks ----------------
    sequence s_sw_busy;
        status_ff.cycle_in_progress [*8];
    endsequence

    property p_rsv_zero;
        @(posedge ref_clk) disable iff (!rst_n_ff) status_ff.rsv == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved status bits not zero");

    property p_sw_busy;
        @(posedge ref_clk) disable iff (!rst_n_ff) sw_go |=> s_sw_busy;
    endproperty
    a_sw_busy: assert property (p_sw_busy) else $error("busy dropped during status write");

    property p_sw_end;
        @(posedge ref_clk) disable iff (!rst_n_ff)
            (state_ff == ST_SW_WAIT && cyc_ff == SW_LAST) |=> ##1
            (!status_ff.cycle_in_progress && !status_ff.write_unlock_latch);
    endproperty
    a_sw_end: assert property (p_sw_end) else $error("status write end state wrong");

    property p_sw_lock;
        @(posedge ref_clk) disable iff (!rst_n_ff)
            $rose(state_ff == ST_SW_WAIT) |-> $past(!locked && status_ff.write_unlock_latch);
    endproperty
    a_sw_lock: assert property (p_sw_lock) else $error("status write while locked");

    property p_prog_unlock;
        @(posedge ref_clk) disable iff (!rst_n_ff)
            $rose(state_ff == ST_PROG_WAIT) |-> $past(status_ff.write_unlock_latch);
    endproperty
    a_prog_unlock: assert property (p_prog_unlock) else $error("program without unlock");

    property p_prog_guard;
        @(posedge ref_clk) disable iff (!rst_n_ff) arr_we |-> !prot;
    endproperty
    a_prog_guard: assert property (p_prog_guard) else $error("program into guarded block");

    property p_prog_clear;
        @(posedge ref_clk) disable iff (!rst_n_ff)
            (state_ff == ST_PROG_COPY) |=> (!status_ff.write_unlock_latch &&
                                            status_ff.cycle_in_progress);
    endproperty
    a_prog_clear: assert property (p_prog_clear) else $error("latch not cleared in program");

    property p_unlock;
        @(posedge ref_clk) disable iff (!rst_n_ff) unlock_go |=> status_ff.write_unlock_latch;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock opcode did not set latch");

    property p_read_busy;
        @(posedge spi_clk) disable iff (!link_arst_b)
            (idx_ff != IDX_OPCODE && !rd_ok_ff) |-> !oe_ff;
    endproperty
    a_read_busy: assert property (p_read_busy) else $error("read served while busy");
endmodule

// file: hw/sfp_pkg.sv
// Shared constants and types for the serial flash command sequencer.
package sfp_pkg;

    // Instruction codes taken from the first byte of a frame.
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_READ          = 8'h03;
    localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
    localparam logic [7:0] OP_FAST_READ     = 8'h0B;

    // Byte positions inside a frame.
    localparam logic [2:0] IDX_OPCODE       = 3'h0;
    localparam logic [2:0] IDX_ADDR_FIRST   = 3'h1;
    localparam logic [2:0] IDX_ADDR_LAST    = 3'h3;
    localparam logic [2:0] IDX_DUMMY        = 3'h4;
    localparam logic [2:0] IDX_FIRST_DATA   = 3'h4;
    localparam logic [2:0] IDX_SAT          = 3'h7;
    localparam logic [2:0] LEN_UNLOCK       = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_PROG_MIN     = 3'h5;
    localparam logic [2:0] BIT_LAST         = 3'h7;

    // Page geometry.
    localparam int PAGE_AW    = 8;
    localparam int PAGE_BYTES = 256;

    // Block guard granularity: the array is split into eighths.
    localparam logic [3:0] GUARD_REGIONS = 4'h8;
    localparam logic [2:0] GUARD_ALL     = 3'h7;

    // Clock rate of ref_clk and unit conversion for timing counts.
    localparam int CLK_MHZ   = 250;
    localparam int NS_PER_US = 1000;

    // Status register layout, most significant bit first.
    typedef struct packed {
        logic       status_guard_bit;
        logic [1:0] rsv;
        logic [2:0] block_guard;
        logic       write_unlock_latch;
        logic       cycle_in_progress;
    } sfp_status_t;

    localparam sfp_status_t STATUS_RST = '0;

    // Self-timed cycle sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0001,
        ST_SW_WAIT   = 4'b0010,
        ST_PROG_WAIT = 4'b0100,
        ST_PROG_COPY = 4'b1000
    } sfp_state_t;

endpackage

// file: hw/sfp_page_buf.sv
// Page staging buffer with registered read data.
`timescale 1ns/10ps
module sfp_page_buf #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // Write port; a later byte to the same offset simply replaces the earlier one.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port.
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

// file: hw/sfp_array_mem.sv
// Flash array model: written from the core clock, read from the link clock.
`timescale 1ns/10ps
module sfp_array_mem #(
    parameter int AW = 16
) (
    input  wire logic          wr_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          rd_clk,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [0:(1<<AW)-1];

    // Writes only happen while reads are refused, so the ports never race.
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data is registered on the rising link clock edge before the falling edge that launches the byte.
    always_ff @(posedge rd_clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// file: tb/sfp_host.sv
// Host serial controller model that frames commands for the sequencer.
`timescale 1ns/10ps
module sfp_host (
    output logic      spi_clk,
    output logic      chip_select_b,
    output logic      serial_in,
    input  wire logic serial_out
);
    // Clock rests low and select high between frames.
    initial begin
        spi_clk = 1'b0;
        chip_select_b = 1'b1;
        serial_in = 1'b0;
    end
    // Sends nbits of tx, then collects nrd bytes; a short nbits aborts mid-byte.
    task automatic frame(input logic [7:0] tx[$], input int nbits, input int nrd,
                         output logic [7:0] rx[$]);
        logic [7:0] sh;
        rx = {};
        // A small offset keeps link edges clear of the core clock edges.
        #1.3;
        chip_select_b = 1'b0;
        for (int i = 0; i < nbits + nrd * 8; i++) begin
            if (i < nbits) serial_in = tx[i / 8][7 - i % 8];
            #24 spi_clk = 1'b1;
            sh = {sh[6:0], serial_out};
            if (i >= nbits && (i - nbits) % 8 == 7) rx.push_back(sh);
            #24 spi_clk = 1'b0;
        end
        #24 chip_select_b = 1'b1;
        serial_in = ~serial_in;
        #48;
    endtask
endmodule

// file: tb/tb.sv
// Self-checking bench comparing the sequencer with a reference memory model.
`timescale 1ns/10ps
module tb;
    import sfp_pkg::*;
    logic        ref_clk, rst_b, write_protect_b, spi_clk, chip_select_b, serial_in;
    logic        serial_out, serial_out_oe, hardware_locked_mode;
    sfp_status_t status;
    int          error_cnt, tests_run, oe_rises;
    logic [7:0]  mem[int];
    logic [7:0]  rx[$];
    sfp_flash_seq #(.MEM_AW(16), .STATUS_WRITE_TIME_NS(100), .PAGE_WRITE_TIME_NS(4000)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk), .chip_select_b(chip_select_b),
        .serial_in(serial_in), .write_protect_b(write_protect_b), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .status(status),
        .hardware_locked_mode(hardware_locked_mode));
    sfp_host host (.spi_clk(spi_clk), .chip_select_b(chip_select_b), .serial_in(serial_in),
        .serial_out(serial_out));
    // Core clock and a count of output-drive starts.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge serial_out_oe) oe_rises++;
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic send(input logic [7:0] tx[$]);
        host.frame(tx, tx.size() * 8, 0, rx);
    endtask
    // Busy shows a few cycles after select rises, so poll only after that.
    task automatic settle;
        int n;
        n = 0;
        repeat (8) @(posedge ref_clk);
        while (status.cycle_in_progress !== 1'b0 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check("busy", {7'h00, status.cycle_in_progress}, 8'h00);
    endtask
    // Unlock then program n random bytes; ok says whether the model takes them.
    task automatic prog(input int a, input int n, input bit ok);
        logic [7:0] tx[$];
        send({OP_WRITE_UNLOCK});
        tx = {OP_PAGE_PROGRAM, 8'h00, a[15:8], a[7:0]};
        for (int i = 0; i < n; i++) begin
            tx.push_back(8'($urandom));
            if (ok) mem[(a & 'hFF00) | ((a + i) & 'hFF)] = tx[$];
        end
        send(tx);
    endtask
    // A refused read leaves the output shifter idle, so the host collects zeros.
    task automatic rd(input logic [7:0] op, input int a, input int n, input bit ok);
        logic [7:0] tx[$];
        int         r;
        r = oe_rises;
        tx = {op, 8'h00, a[15:8], a[7:0]};
        if (op == OP_FAST_READ) tx.push_back(8'($urandom));
        host.frame(tx, tx.size() * 8, n, rx);
        check("oe", {7'h00, serial_out_oe}, 8'h00);
        check("oe_starts", 8'(oe_rises - r), {7'h00, ok});
        for (int i = 0; i < n; i++) check("data", rx[i], ok ? mem[(a + i) & 'hFFFF] : 8'h00);
    endtask
    // Watchdog well beyond the expected run length.
    initial begin
        #350000;
        error_cnt++;
        summarize;
    end
    initial begin
        rst_b = 1'b0;
        write_protect_b = 1'b1;
        void'($urandom(32'h9553));
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("status", status, 8'h00);
        prog('h10FE, 3, 1'b1);
        settle;
        check("status", status, 8'h00);
        prog('hFFFF, 1, 1'b1);
        settle;
        prog('h0000, 1, 1'b1);
        settle;
        send({OP_WRITE_UNLOCK});
        host.frame({OP_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00, 8'h5A}, 36, 0, rx);
        settle;
        check("status", status, 8'h02);
        prog('h20F0, 257, 1'b1);
        rd(OP_READ, 'h1000, 1, 1'b0);
        check("oe", oe_rises[7:0], 8'h00);
        settle;
        rd(OP_READ, 'h10FE, 2, 1'b1);
        rd(OP_READ, 'h1000, 1, 1'b1);
        rd(OP_FAST_READ, 'hFFFF, 2, 1'b1);
        rd(OP_READ, 'h20F0, 2, 1'b1);
        send({OP_WRITE_UNLOCK});
        host.frame({OP_STATUS_WRITE, 8'hFF}, 12, 0, rx);
        settle;
        check("status", status, 8'h02);
        send({OP_STATUS_WRITE, 8'hFF});
        settle;
        check("status", status, 8'h9C);
        prog('h1000, 1, 1'b0);
        settle;
        check("status", status, 8'h9E);
        write_protect_b <= 1'b0;
        send({OP_STATUS_WRITE, 8'h00});
        settle;
        check("status", status, 8'h9E);
        check("locked", {7'h00, hardware_locked_mode}, 8'h01);
        rd(OP_READ, 'h1000, 1, 1'b1);
        summarize;
    end
endmodule
